// ==== icc_pkg.sv ====
`timescale 1ns/100ps
package icc_pkg;
   // Geometry
   localparam int ICC_NUM_EP = 4;
   localparam int ICC_EPW = 2;
   localparam int ICC_AW = 8;
   localparam int ICC_MAP_AW = 10;
   localparam int ICC_MAP_DW = 5;

   // Register byte offsets
   localparam logic [ICC_AW-1:0] ICC_OFF_EP_CFG0 = 8'h00;
   localparam logic [ICC_AW-1:0] ICC_OFF_EP_END = 8'h10;
   localparam logic [ICC_AW-1:0] ICC_OFF_TBL_WR = 8'h10;
   localparam logic [ICC_AW-1:0] ICC_OFF_CNT_FRM = 8'h14;
   localparam logic [ICC_AW-1:0] ICC_OFF_CNT_DROP = 8'h18;

   // Reset values and codes
   localparam logic [31:0] ICC_EP_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] ICC_TBL_WR_RST = 32'h0000_0000;
   localparam logic [3:0] ICC_COS_DISCARD = 4'hF;
   localparam logic [1:0] ICC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ICC_RESP_SLVERR = 2'h2;

   // Table bank select inside one endpoint's slice of the map memory
   localparam logic [1:0] ICC_SEL_V4 = 2'h0;
   localparam logic [1:0] ICC_SEL_V6 = 2'h1;
   localparam logic [1:0] ICC_SEL_CTRL_PROTO = 2'h2;

   // Modes
   typedef enum logic [1:0] {ICC_CLS_ENDPOINT, ICC_CLS_PCP, ICC_CLS_DSCP, ICC_CLS_RSVD} icc_cls_mode_t;
   typedef enum logic [1:0] {ICC_COL_FIXED, ICC_COL_DEI, ICC_COL_PCP, ICC_COL_DSCP} icc_col_mode_t;
   typedef enum logic [1:0] {ICC_IP_NONE, ICC_IP_V4, ICC_IP_V6, ICC_IP_OTHER} icc_ip_kind_t;

   // Per-endpoint configuration word
   typedef struct packed {
      logic [15:0] rsvd;
      logic v6_off;
      logic v4_off;
      logic color_aware;
      logic fixed_yellow;
      icc_col_mode_t color_mode;
      logic [3:0] cos_nonip;
      logic [3:0] cos_single;
      icc_cls_mode_t class_mode;
   } icc_ep_cfg_t;

   // Table write word
   typedef struct packed {
      logic [16:0] rsvd;
      logic [ICC_EPW-1:0] ep;
      logic [1:0] sel;
      logic [5:0] idx;
      logic present;
      logic [3:0] cos;
   } icc_tbl_wr_t;

   // Parsed frame from the port MAC
   typedef struct packed {
      logic ingress;
      logic [ICC_EPW-1:0] ep;
      logic ctag;
      logic dei;
      icc_ip_kind_t ip_kind;
      logic [7:0] tos;
      logic layer2_control_frame;
      logic [5:0] proto;
      logic in_env;
      logic color_in;
   } icc_frame_t;

   // Classification result
   typedef struct packed {
      logic ingress;
      logic [ICC_EPW-1:0] ep;
      logic [3:0] cos;
      logic yellow;
      logic color_used;
   } icc_result_t;

   // AXI4-Lite carriers
   typedef struct packed {
      logic awvalid;
      logic [ICC_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ICC_AW-1:0] araddr;
      logic rready;
   } icc_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } icc_axil_rsp_t;
endpackage

// Map memory: one write port, two registered read ports
module icc_map_ram
   import icc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write port
   input wire logic we,
   input wire logic [ICC_MAP_AW-1:0] waddr,
   input wire logic [ICC_MAP_DW-1:0] wdata,
   // Read ports
   input wire logic [ICC_MAP_AW-1:0] raddr_a,
   input wire logic [ICC_MAP_AW-1:0] raddr_b,
   output logic [ICC_MAP_DW-1:0] rdata_a,
   output logic [ICC_MAP_DW-1:0] rdata_b
);
   logic [ICC_MAP_DW-1:0] mem [2**ICC_MAP_AW];

   // Cleared on reset so that lookups never return unknown entries
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 2**ICC_MAP_AW; i++) begin
            mem[i] <= '0;
         end
         rdata_a <= '0;
         rdata_b <= '0;
      end else begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule

// ==== icc_classifier.sv ====
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - DSCP mode: data frame class comes from its IPv4 or IPv6 DSCP.
// - Separate full IPv4 and IPv6 DSCP tables; every DSCP yields one class.
// - One DSCP may give different classes for IPv4 and IPv6.
// - DSCP mode: non-IP data frames get one configured class.
// - IPv6 or IPv4 can be treated as non-IP by configuration.
// - Control frame with a table entry for its protocol takes that class.
// - Control frame without table entry is classified as a data frame.
// - OAM frames take the class a matching data frame would get.
// - Each ingress frame gets exactly one colour, Green or Yellow.
// - Colour selected per endpoint: fixed or DEI; PCP and DSCP selectors give Green.
// - Fixed selector applies one configured colour to all endpoint frames.
// - DEI selector: DEI 0 gives Green, DEI 1 gives Yellow.
// - DEI selector: frame without customer tag is Green.
// - Colour logic touches ingress frames only, never egress.
// - Colour matters only outside envelopes or when colour aware.
// - Frames whose class is the Discard name are discarded.
// - DSCP mode: IP data frame takes the class chosen by its endpoint's table, non-IP data frame takes cos_nonip; other modes use cos_single.
module icc_classifier
   import icc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Parsed frames from the MAC
   input wire logic in_valid,
   input wire icc_frame_t in_frm,
   // Results toward policing
   output logic out_valid,
   output logic out_drop,
   output icc_result_t out_res,
   // Register bus
   input wire icc_axil_req_t axi_req,
   output icc_axil_rsp_t axi_rsp
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_got;
      logic w_got;
      logic [ICC_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      icc_ep_cfg_t [ICC_NUM_EP-1:0] cfg;
      icc_tbl_wr_t tbl_last;
      logic [31:0] cnt_frm;
      logic [31:0] cnt_drop;
      logic tbl_we;
      logic [ICC_MAP_AW-1:0] tbl_waddr;
      logic [ICC_MAP_DW-1:0] tbl_wdata;
      logic s1_valid;
      icc_frame_t s1_frm;
      icc_ep_cfg_t s1_cfg;
      logic out_valid;
      logic out_drop;
      icc_result_t out_res;
   } icc_state_t;

   icc_state_t st_r;
   icc_state_t st_nxt;
   icc_ep_cfg_t in_cfg;
   logic [ICC_MAP_AW-1:0] raddr_a;
   logic [ICC_MAP_AW-1:0] raddr_b;
   logic [ICC_MAP_DW-1:0] rdata_a;
   logic [ICC_MAP_DW-1:0] rdata_b;

   // Byte-lane merge for partial writes
   function automatic logic [31:0] icc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Configuration of the endpoint that the incoming frame belongs to
   assign in_cfg = st_r.cfg[in_frm.ep];

   // Lookup addresses; DSCP from the top six TOS bits, one bank per IP version
   assign raddr_a = {in_frm.ep, (in_frm.ip_kind == ICC_IP_V6) ? ICC_SEL_V6 : ICC_SEL_V4,
                     in_frm.tos[7:2]};
   assign raddr_b = {in_frm.ep, ICC_SEL_CTRL_PROTO, in_frm.proto};

   icc_map_ram u_map (
      .clk(clk),
      .reset(reset),
      .we(st_r.tbl_we),
      .waddr(st_r.tbl_waddr),
      .wdata(st_r.tbl_wdata),
      .raddr_a(raddr_a),
      .raddr_b(raddr_b),
      .rdata_a(rdata_a),
      .rdata_b(rdata_b)
   );

   // Next-state logic: bus slave, pipeline and classification
   always_comb begin
      icc_ep_cfg_t c;
      icc_tbl_wr_t tw;
      icc_frame_t f;
      icc_result_t r;
      logic ycol;
      logic drop;
      c = '0;
      tw = '0;
      f = '0;
      r = '0;
      ycol = 1'b0;
      drop = 1'b0;
      st_nxt = st_r;
      st_nxt.tbl_we = 1'b0;

      // Write address and data, taken in either order
      if (axi_req.awvalid && st_r.awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = axi_req.awaddr;
         st_nxt.awready = 1'b0;
      end
      if (axi_req.wvalid && st_r.wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = axi_req.wdata;
         st_nxt.wstrb = axi_req.wstrb;
         st_nxt.wready = 1'b0;
      end

      // Perform the write once both halves are held
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = ICC_RESP_OKAY;
         if (st_r.awaddr >= ICC_OFF_EP_CFG0 && st_r.awaddr < ICC_OFF_EP_END) begin
            c = icc_ep_cfg_t'(icc_merge(st_r.cfg[st_r.awaddr[ICC_EPW+1:2]], st_r.wdata,
                                        st_r.wstrb));
            c.rsvd = '0;
            st_nxt.cfg[st_r.awaddr[ICC_EPW+1:2]] = c;
         end else if (st_r.awaddr[ICC_AW-1:2] == ICC_OFF_TBL_WR[ICC_AW-1:2]) begin
            tw = icc_tbl_wr_t'(icc_merge(st_r.tbl_last, st_r.wdata, st_r.wstrb));
            tw.rsvd = '0;
            st_nxt.tbl_last = tw;
            st_nxt.tbl_we = 1'b1;
            st_nxt.tbl_waddr = {tw.ep, tw.sel, tw.idx};
            st_nxt.tbl_wdata = {tw.present, tw.cos};
         end else if (st_r.awaddr[ICC_AW-1:2] == ICC_OFF_CNT_FRM[ICC_AW-1:2]) begin
            st_nxt.bresp = ICC_RESP_OKAY; // Counters ignore writes
         end else if (st_r.awaddr[ICC_AW-1:2] == ICC_OFF_CNT_DROP[ICC_AW-1:2]) begin
            st_nxt.bresp = ICC_RESP_OKAY;
         end else begin
            st_nxt.bresp = ICC_RESP_SLVERR;
         end
      end

      // Write response accepted, reopen both channels
      if (st_r.bvalid && axi_req.bready) begin
         st_nxt.bvalid = 1'b0;
         st_nxt.awready = 1'b1;
         st_nxt.wready = 1'b1;
      end

      // Read channel
      if (axi_req.arvalid && st_r.arready) begin
         st_nxt.arready = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = ICC_RESP_OKAY;
         st_nxt.rdata = '0;
         if (axi_req.araddr >= ICC_OFF_EP_CFG0 && axi_req.araddr < ICC_OFF_EP_END) begin
            st_nxt.rdata = st_r.cfg[axi_req.araddr[ICC_EPW+1:2]];
         end else if (axi_req.araddr[ICC_AW-1:2] == ICC_OFF_TBL_WR[ICC_AW-1:2]) begin
            st_nxt.rdata = st_r.tbl_last;
         end else if (axi_req.araddr[ICC_AW-1:2] == ICC_OFF_CNT_FRM[ICC_AW-1:2]) begin
            st_nxt.rdata = st_r.cnt_frm;
         end else if (axi_req.araddr[ICC_AW-1:2] == ICC_OFF_CNT_DROP[ICC_AW-1:2]) begin
            st_nxt.rdata = st_r.cnt_drop;
         end else begin
            st_nxt.rresp = ICC_RESP_SLVERR;
         end
      end
      if (st_r.rvalid && axi_req.rready) begin
         st_nxt.rvalid = 1'b0;
         st_nxt.arready = 1'b1;
      end

      // Stage 1: frame and its endpoint settings, aligned with table reads
      st_nxt.s1_valid = in_valid;
      st_nxt.s1_frm = in_frm;
      st_nxt.s1_cfg = in_cfg;

      // Stage 2: class-of-service name
      f = st_r.s1_frm;
      c = st_r.s1_cfg;
      r.ingress = f.ingress;
      r.ep = f.ep;
      if (f.layer2_control_frame && rdata_b[ICC_MAP_DW-1]) begin
         r.cos = rdata_b[3:0];
      end else if (c.class_mode == ICC_CLS_DSCP) begin
         // Control frames with no entry and OAM frames fall through here
         if (f.ip_kind == ICC_IP_V4 && !c.v4_off) begin
            r.cos = rdata_a[3:0];
         end else if (f.ip_kind == ICC_IP_V6 && !c.v6_off) begin
            r.cos = rdata_a[3:0];
         end else begin
            r.cos = c.cos_nonip;
         end
      end else begin
         r.cos = c.cos_single;
      end

      // Colour from the endpoint selector; PCP and DSCP selectors give Green
      case (c.color_mode)
         ICC_COL_FIXED: begin
            ycol = c.fixed_yellow;
         end
         ICC_COL_DEI: begin
            ycol = f.ctag & f.dei;
         end
         default: begin
            ycol = 1'b0;
         end
      endcase
      r.color_used = !f.in_env || c.color_aware;
      r.yellow = r.color_used & ycol;

      // Egress frames pass with their own colour and no class
      if (!f.ingress) begin
         r.cos = '0;
         r.color_used = 1'b0;
         r.yellow = f.color_in;
      end
      drop = f.ingress && (r.cos == ICC_COS_DISCARD);

      // Output register and counters
      st_nxt.out_valid = st_r.s1_valid && !drop;
      st_nxt.out_drop = st_r.s1_valid && drop;
      if (st_r.s1_valid) begin
         st_nxt.out_res = r;
         st_nxt.cnt_frm = st_r.cnt_frm + 32'h0000_0001;
         if (drop) begin
            st_nxt.cnt_drop = st_r.cnt_drop + 32'h0000_0001;
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r <= '0;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
         st_r.cfg <= {ICC_NUM_EP{ICC_EP_CFG_RST}};
         st_r.tbl_last <= icc_tbl_wr_t'(ICC_TBL_WR_RST);
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign out_valid = st_r.out_valid;
   assign out_drop = st_r.out_drop;
   assign out_res = st_r.out_res;
   assign axi_rsp.awready = st_r.awready;
   assign axi_rsp.wready = st_r.wready;
   assign axi_rsp.bvalid = st_r.bvalid;
   assign axi_rsp.bresp = st_r.bresp;
   assign axi_rsp.arready = st_r.arready;
   assign axi_rsp.rvalid = st_r.rvalid;
   assign axi_rsp.rdata = st_r.rdata;
   assign axi_rsp.rresp = st_r.rresp;

   // Checks on the classifier pipeline
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic in_ing;
   logic out_evt;
   assign in_ing = in_valid && in_frm.ingress;
   assign out_evt = st_r.out_valid || st_r.out_drop;

   property p_one_result;
      in_valid |-> ##2 (out_evt && !(st_r.out_valid && st_r.out_drop));
   endproperty
   a_one_result: assert property (p_one_result) else $error("frame lost or doubled");

   property p_dei_color;
      in_ing && in_cfg.color_mode == ICC_COL_DEI && !in_frm.in_env && in_frm.ctag
         |-> ##2 out_res.yellow == $past(in_frm.dei, 2);
   endproperty
   a_dei_color: assert property (p_dei_color) else $error("DEI colour wrong");

   property p_untag_green;
      in_ing && in_cfg.color_mode == ICC_COL_DEI && !in_frm.ctag |-> ##2 !out_res.yellow;
   endproperty
   a_untag_green: assert property (p_untag_green) else $error("untagged not green");

   property p_fixed_color;
      in_ing && in_cfg.color_mode == ICC_COL_FIXED && !in_frm.in_env
         |-> ##2 out_res.yellow == $past(in_cfg.fixed_yellow, 2);
   endproperty
   a_fixed_color: assert property (p_fixed_color) else $error("fixed colour wrong");

   property p_egress_keep;
      in_valid && !in_frm.ingress
         |-> ##2 st_r.out_valid && out_res.yellow == $past(in_frm.color_in, 2);
   endproperty
   a_egress_keep: assert property (p_egress_keep) else $error("egress recoloured");

   property p_env_blind;
      in_ing && in_frm.in_env && !in_cfg.color_aware
         |-> ##2 !out_res.yellow && !out_res.color_used;
   endproperty
   a_env_blind: assert property (p_env_blind) else $error("blind colour used");

   property p_no_discard_out;
      st_r.out_valid && out_res.ingress |-> out_res.cos != ICC_COS_DISCARD;
   endproperty
   a_no_discard_out: assert property (p_no_discard_out) else $error("discard passed");

   // Counter moves in the same edge that raises the drop pulse
   property p_drop_count;
      st_r.out_drop |-> st_r.cnt_drop == $past(st_r.cnt_drop) + 32'h0000_0001;
   endproperty
   a_drop_count: assert property (p_drop_count) else $error("drop not counted");

   property p_single_cos;
      in_ing && !in_frm.layer2_control_frame && in_cfg.class_mode == ICC_CLS_ENDPOINT
         |-> ##2 out_res.cos == $past(in_cfg.cos_single, 2);
   endproperty
   a_single_cos: assert property (p_single_cos) else $error("endpoint class wrong");

   property p_nonip_cos;
      in_ing && !in_frm.layer2_control_frame && in_cfg.class_mode == ICC_CLS_DSCP
         && in_frm.ip_kind == ICC_IP_NONE
         |-> ##2 out_res.cos == $past(in_cfg.cos_nonip, 2);
   endproperty
   a_nonip_cos: assert property (p_nonip_cos) else $error("non-IP class wrong");

   // Main scenarios
   property p_cov_yellow;
      st_r.out_valid && out_res.ingress && out_res.yellow;
   endproperty
   c_cov_yellow: cover property (p_cov_yellow);

   property p_cov_drop;
      st_r.out_drop;
   endproperty
   c_cov_drop: cover property (p_cov_drop);

   property p_cov_ctrl_hit;
      st_r.s1_valid && st_r.s1_frm.layer2_control_frame && rdata_b[ICC_MAP_DW-1];
   endproperty
   c_cov_ctrl_hit: cover property (p_cov_ctrl_hit);
endmodule

// ==== icc_mac_model.sv ====
`timescale 1ns/100ps
// Port MAC stand-in: one parsed descriptor per call
module icc_mac_model
   import icc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Descriptor stream toward the classifier
   output logic in_valid,
   output icc_frame_t in_frm
);
   // Idle stream at time zero
   initial begin
      in_valid = 1'b0;
      in_frm = '0;
   end

   // One-cycle descriptor, then its inverse so stale fields are never trusted
   task automatic send(input icc_frame_t f);
      @(posedge clk);
      in_valid <= 1'b1;
      in_frm <= f;
      @(posedge clk);
      in_valid <= 1'b0;
      in_frm <= ~f;
   endtask
endmodule

// ==== icc_classifier_tb.sv ====
`timescale 1ns/100ps
module icc_classifier_tb
   import icc_pkg::*;
();
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic in_valid;
   icc_frame_t in_frm;
   logic out_valid;
   logic out_drop;
   icc_result_t out_res;
   icc_axil_req_t axi_req = '0;
   icc_axil_rsp_t axi_rsp;
   int error_cnt = 0;
   int check_count = 0;
   logic [31:0] nfrm = 32'h0;
   logic [31:0] ndrop = 32'h0;

   // 100 MHz clock
   always #5 clk = ~clk;

   // Frame source and block under test
   icc_mac_model mac_u (.clk(clk), .in_valid(in_valid), .in_frm(in_frm));
   icc_classifier dut_u (.clk(clk), .reset(reset), .in_valid(in_valid), .in_frm(in_frm),
      .out_valid(out_valid), .out_drop(out_drop), .out_res(out_res),
      .axi_req(axi_req), .axi_rsp(axi_rsp));

   // Verdict and end of run
   task automatic complete_run();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Single comparison point
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A wait that ran out of cycles
   task automatic timeout();
      error_cnt++;
      $display("[FAIL] %0t: no answer in time", $time);
      complete_run();
   endtask

   // Register write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (axi_req.awvalid && axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
         if (axi_rsp.bvalid === 1'b1) begin
            axi_req.bready <= 1'b0;
            check(32'(axi_rsp.bresp), 32'(er));
            break;
         end
      end
      if (n == 50) timeout();
   endtask

   // Register read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (axi_req.arvalid && axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
         if (axi_rsp.rvalid === 1'b1) begin
            axi_req.rready <= 1'b0;
            check(axi_rsp.rdata, ed);
            check(32'(axi_rsp.rresp), 32'(er));
            break;
         end
      end
      if (n == 50) timeout();
   endtask

   // Endpoint configuration word
   function automatic logic [31:0] cfgw(input icc_cls_mode_t cl, input logic [3:0] single,
      input logic [3:0] nonip, input icc_col_mode_t col_mode, input logic fy, input logic ca,
      input logic v4o, input logic v6o);
      return {16'h0, v6o, v4o, ca, fy, col_mode, nonip, single, cl};
   endfunction

   // Descriptor builder, egress colour always yellow
   function automatic icc_frame_t mk(input logic ing, input logic [1:0] ep, input icc_ip_kind_t k,
      input logic [7:0] tos, input logic l2, input logic [5:0] pr, input logic ct,
      input logic de, input logic env);
      return {ing, ep, ct, de, k, tos, l2, pr, env, 1'b1};
   endfunction

   task automatic cfg(input logic [1:0] ep, input logic [31:0] w);
      wr(ICC_OFF_EP_CFG0 + {4'h0, ep, 2'b00}, w, ICC_RESP_OKAY);
   endtask

   task automatic tw(input logic [1:0] ep, input logic [1:0] sel, input logic [5:0] idx,
      input logic pr, input logic [3:0] cos);
      wr(ICC_OFF_TBL_WR, {17'h0, ep, sel, idx, pr, cos}, ICC_RESP_OKAY);
   endtask

   // Send one frame; its result shows right after the edge that follows the taking edge
   task automatic run_frame(input icc_frame_t f, input logic drop, input logic [3:0] cos,
      input logic yel, input logic used);
      int n;
      mac_u.send(f);
      for (n = 0; n < 8; n++) begin
         @(posedge clk);
         #1;
         if (out_valid === 1'b1 || out_drop === 1'b1) break;
      end
      if (n == 8) begin
         timeout();
      end else begin
         nfrm++;
         if (drop) ndrop++;
         check(32'(n), 32'd0);
         check(32'(out_drop), 32'(drop));
         check(32'(out_valid), 32'(!drop));
         check(32'(out_res), 32'({f.ingress, f.ep, cos, yel, used}));
      end
   endtask

   // Main sequence
   initial begin
      int m;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(ICC_OFF_EP_CFG0, ICC_EP_CFG_RST, ICC_RESP_OKAY);
      rd(ICC_OFF_TBL_WR, ICC_TBL_WR_RST, ICC_RESP_OKAY);
      rd(ICC_OFF_CNT_DROP, 32'h0, ICC_RESP_OKAY);
      rd(8'h1C, 32'h0, ICC_RESP_SLVERR);
      wr(8'h1C, 32'h0000_00FF, ICC_RESP_SLVERR);
      run_frame(mk(1, 3, ICC_IP_V4, 8'h97, 0, 0, 0, 0, 0), 0, 4'h0, 0, 1);
      // Endpoint class, fixed yellow, envelope and colour awareness
      cfg(0, cfgw(ICC_CLS_ENDPOINT, 4'h3, 4'h0, ICC_COL_FIXED, 1, 0, 0, 0));
      run_frame(mk(1, 0, ICC_IP_V4, 8'h14, 0, 0, 0, 0, 0), 0, 4'h3, 1, 1);
      run_frame(mk(1, 0, ICC_IP_V6, 8'h14, 0, 0, 0, 0, 1), 0, 4'h3, 0, 0);
      cfg(0, cfgw(ICC_CLS_ENDPOINT, 4'h3, 4'h0, ICC_COL_FIXED, 1, 1, 0, 0));
      run_frame(mk(1, 0, ICC_IP_NONE, 8'h00, 0, 0, 0, 0, 1), 0, 4'h3, 1, 1);
      // DSCP class with separate IPv4 and IPv6 tables
      cfg(1, cfgw(ICC_CLS_DSCP, 4'h1, 4'h4, ICC_COL_FIXED, 0, 0, 0, 0));
      tw(1, ICC_SEL_V4, 6'd37, 0, 4'h2);
      tw(1, ICC_SEL_V6, 6'd37, 0, 4'h7);
      tw(1, ICC_SEL_V4, 6'd63, 0, ICC_COS_DISCARD);
      tw(1, ICC_SEL_CTRL_PROTO, 6'd9, 1, 4'h6);
      run_frame(mk(1, 1, ICC_IP_V4, 8'h97, 0, 0, 0, 0, 0), 0, 4'h2, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V6, 8'h97, 0, 0, 0, 0, 0), 0, 4'h7, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V6, 8'h03, 0, 0, 0, 0, 0), 0, 4'h0, 0, 1);
      run_frame(mk(1, 1, ICC_IP_NONE, 8'h97, 0, 0, 0, 0, 0), 0, 4'h4, 0, 1);
      run_frame(mk(1, 1, ICC_IP_OTHER, 8'h97, 0, 0, 0, 0, 0), 0, 4'h4, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V4, 8'hFC, 0, 0, 0, 0, 0), 1, ICC_COS_DISCARD, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V4, 8'h97, 1, 9, 0, 0, 0), 0, 4'h6, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V4, 8'h97, 1, 10, 0, 0, 0), 0, 4'h2, 0, 1);
      // Single IP version by configuration
      cfg(1, cfgw(ICC_CLS_DSCP, 4'h1, 4'h4, ICC_COL_FIXED, 0, 0, 0, 1));
      run_frame(mk(1, 1, ICC_IP_V6, 8'h97, 0, 0, 0, 0, 0), 0, 4'h4, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V4, 8'h97, 0, 0, 0, 0, 0), 0, 4'h2, 0, 1);
      cfg(1, cfgw(ICC_CLS_DSCP, 4'h1, 4'h4, ICC_COL_FIXED, 0, 0, 1, 0));
      run_frame(mk(1, 1, ICC_IP_V4, 8'h97, 0, 0, 0, 0, 0), 0, 4'h4, 0, 1);
      run_frame(mk(1, 1, ICC_IP_V6, 8'h97, 0, 0, 0, 0, 0), 0, 4'h7, 0, 1);
      // Every colour selector on a tagged DEI=1 frame
      for (m = 0; m < 4; m++) begin
         cfg(2, cfgw(ICC_CLS_ENDPOINT, 4'h5, 4'h0, icc_col_mode_t'(m), 1, 0, 0, 0));
         run_frame(mk(1, 2, ICC_IP_NONE, 8'h00, 0, 0, 1, 1, 0), 0, 4'h5, m < 2, 1);
      end
      // DEI selector over tag presence and DEI value
      cfg(2, cfgw(ICC_CLS_ENDPOINT, 4'h5, 4'h0, ICC_COL_DEI, 0, 0, 0, 0));
      for (m = 0; m < 4; m++) begin
         run_frame(mk(1, 2, ICC_IP_NONE, 8'h00, 0, 0, m[1], m[0], 0), 0, 4'h5, m == 3, 1);
      end
      run_frame(mk(0, 2, ICC_IP_V4, 8'h97, 0, 0, 1, 0, 0), 0, 4'h0, 1, 0);
      // Reserved bits and a discard class from cos_single in the reserved class mode
      wr(ICC_OFF_EP_CFG0 + 8'h0C, 32'hFFFF_FFFF, ICC_RESP_OKAY);
      rd(ICC_OFF_EP_CFG0 + 8'h0C, 32'h0000_FFFF, ICC_RESP_OKAY);
      run_frame(mk(1, 3, ICC_IP_V4, 8'h97, 0, 0, 1, 1, 0), 1, ICC_COS_DISCARD, 0, 1);
      // Counters are read-only and count every result
      rd(ICC_OFF_CNT_FRM, nfrm, ICC_RESP_OKAY);
      rd(ICC_OFF_CNT_DROP, ndrop, ICC_RESP_OKAY);
      wr(ICC_OFF_CNT_FRM, 32'h0, ICC_RESP_OKAY);
      rd(ICC_OFF_CNT_FRM, nfrm, ICC_RESP_OKAY);
      complete_run();
   end
endmodule
